//--- rtl/wdts_timer.sv
// watchdog timer with sleep handling, status flags, interrupts and register file
//
// Behaviour
// R1: awake and enabled, reaching the time-out before a clear requests device reset
// R2: count steps only on 31 kHz oscillator ticks; 1:32 gives the 1 ms base
// R3: mode 11 keeps the watchdog active always, sleep included, ignoring software enable
// R4: mode 10 keeps it active awake and disabled during sleep
// R5: mode 01 follows the software enable bit, awake or asleep
// R6: mode 00 keeps it disabled and cleared always
// R7: period select spans 1 ms to 256 s and resets to two seconds
// R8: code 0 is 1:32, each step doubles to 10010; above is 1:32; reset 01011
// R9: reset, clear instruction, sleep entry/exit, oscillator fail, disable all clear count
// R10: crystal clock wake holds count clear while start-up timer runs; others clear once
// R11: internal oscillator divider changes leave the count alone
// R12: sleep entry clears count, which keeps counting if enabled in sleep
// R13: time-out in sleep wakes the device and updates both status flags
// R14: sleep instruction clears power-down flag and sets time-out flag
// R15: time-out is a one-cycle pulse; count restarts from zero afterwards
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module wdts_timer (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // configuration word
  input  wire logic [1:0]  watchdogModeCfg,
  // core, clock module and sleep controller
  input  wire logic        clearWatchdogInstr,
  input  wire logic        sleepInstr,
  input  wire logic        wakeEvent,
  input  wire logic        oscFail,
  input  wire logic        crystalClock,
  input  wire logic        oscStartupTimerRunning,
  input  wire logic        lowFreqOscTick,
  // requests and flags
  output logic             watchdogResetReq,
  output logic             watchdogWakeReq,
  output logic             timeoutFlagN,
  output logic             powerdownFlagN,
  output logic             inSleep,
  output logic             irq
);

  typedef struct packed {
    wdts_pkg::wdts_pwr_t         pwr;
    logic [wdts_pkg::CTRL_W-1:0] control;
    logic                        timeoutFlagN;
    logic                        powerdownFlagN;
    logic [wdts_pkg::IRQ_W-1:0]  irqStat;
    logic [wdts_pkg::IRQ_W-1:0]  irqEn;
    logic                        resetReq;
    logic                        wakeReq;
  } wdts_state_t;

  wdts_state_t                st;
  wdts_state_t                next_st;
  logic [7:0]                 rdAddr;
  logic                       rdHit;
  logic [31:0]                rdValue;
  logic                       wrStb;
  logic [7:0]                 wrAddr;
  logic [31:0]                wrData;
  logic [wdts_pkg::CNT_W-1:0] wdogCount;
  logic                       wdogExpire;
  logic                       active;
  logic                       enterSleep;
  logic                       exitSleep;
  logic                       clearCnt;
  logic [4:0]                 periodSel;
  logic                       swEnable;
  logic [wdts_pkg::IRQ_W-1:0] irqSet;
  logic [wdts_pkg::IRQ_W-1:0] irqClr;

  wdts_ahb_slave u_bus (
    .mclk      (mclk),
    .resetn    (resetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rdAddr    (rdAddr),
    .rdHit     (rdHit),
    .rdValue   (rdValue),
    .wrStb     (wrStb),
    .wrAddr    (wrAddr),
    .wrData    (wrData)
  );

  // the count sees only its own tick, clear and period select, so oscillator divider changes cannot disturb it
  wdts_counter u_cnt (
    .mclk      (mclk),
    .resetn    (resetn),
    .clear     (clearCnt),
    .lfoTick   (lowFreqOscTick), // R2 R11
    .periodSel (periodSel), // R8
    .count     (wdogCount),
    .expire    (wdogExpire)
  );

  assign periodSel  = st.control[wdts_pkg::PSEL_LSB +: wdts_pkg::PSEL_W];
  assign swEnable   = st.control[wdts_pkg::SWEN_BIT];
  assign active     = wdts_pkg::is_active(watchdogModeCfg, swEnable, st.pwr == wdts_pkg::PWR_SLEEP); // R3 R4 R5 R6
  assign enterSleep = sleepInstr && (st.pwr == wdts_pkg::PWR_AWAKE);
  assign exitSleep  = (st.pwr == wdts_pkg::PWR_SLEEP) && (wakeEvent || wdogExpire);
  assign clearCnt   = !active || clearWatchdogInstr || enterSleep || exitSleep || oscFail
                      || (st.pwr == wdts_pkg::PWR_OSTHOLD); // R9 R10 R12

  assign irqSet = {oscFail,
                   wdogExpire && (st.pwr == wdts_pkg::PWR_SLEEP),
                   wdogExpire && (st.pwr != wdts_pkg::PWR_SLEEP)};
  assign irqClr = (wrStb && (wrAddr == wdts_pkg::OFS_IRQ_CLR)) ? wrData[wdts_pkg::IRQ_W-1:0] : '0;

  always_comb begin
    next_st          = st;
    next_st.resetReq = 1'b0;
    next_st.wakeReq  = 1'b0;
    // a new event beats a clear in the same cycle
    next_st.irqStat  = (st.irqStat & ~irqClr) | irqSet;
    if (wrStb && (wrAddr == wdts_pkg::OFS_CONTROL)) begin
      next_st.control = wrData[wdts_pkg::CTRL_W-1:0]; // R7
    end
    if (wrStb && (wrAddr == wdts_pkg::OFS_IRQ_EN)) begin
      next_st.irqEn = wrData[wdts_pkg::IRQ_W-1:0];
    end
    if (clearWatchdogInstr) begin
      next_st.timeoutFlagN   = 1'b1;
      next_st.powerdownFlagN = 1'b1;
    end
    case (st.pwr)
      wdts_pkg::PWR_AWAKE: begin
        if (wdogExpire) begin
          next_st.resetReq     = 1'b1; // R1 R15
          next_st.timeoutFlagN = 1'b0;
        end else if (enterSleep) begin
          next_st.pwr            = wdts_pkg::PWR_SLEEP;
          next_st.powerdownFlagN = 1'b0; // R14
          next_st.timeoutFlagN   = 1'b1; // R14
        end
      end
      wdts_pkg::PWR_SLEEP: begin
        if (wdogExpire) begin
          next_st.wakeReq        = 1'b1; // R13 R15
          next_st.timeoutFlagN   = 1'b0; // R13
          next_st.powerdownFlagN = 1'b0; // R13
        end
        if (exitSleep) begin
          next_st.pwr = crystalClock ? wdts_pkg::PWR_OSTHOLD : wdts_pkg::PWR_AWAKE; // R10
        end
      end
      wdts_pkg::PWR_OSTHOLD: begin
        // the start-up timer is expected to be running on the first hold cycle
        if (!oscStartupTimerRunning) begin
          next_st.pwr = wdts_pkg::PWR_AWAKE; // R10
        end
      end
      default: begin
        next_st.pwr = wdts_pkg::PWR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st                <= '0;
      st.pwr            <= wdts_pkg::PWR_AWAKE;
      st.control        <= wdts_pkg::CTRL_RESET; // R7 R8
      st.timeoutFlagN   <= 1'b1;
      st.powerdownFlagN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  function automatic logic [31:0] read_word(input logic [7:0] addr, input wdts_state_t s,
                                            input logic [1:0] mode, input logic act,
                                            input logic [wdts_pkg::CNT_W-1:0] cnt);
    logic [31:0] v;
    v = 32'h00000000;
    case (addr)
      wdts_pkg::OFS_CONTROL:  v[wdts_pkg::CTRL_W-1:0] = s.control;
      wdts_pkg::OFS_STATUS: begin
        v[wdts_pkg::ST_TMOUT_BIT]            = s.timeoutFlagN;
        v[wdts_pkg::ST_PWRDN_BIT]            = s.powerdownFlagN;
        v[wdts_pkg::ST_MODE_LSB +: 2]        = mode;
        v[wdts_pkg::ST_SLEEP_BIT]            = (s.pwr == wdts_pkg::PWR_SLEEP);
        v[wdts_pkg::ST_HOLD_BIT]             = (s.pwr == wdts_pkg::PWR_OSTHOLD);
        v[wdts_pkg::ST_ACTIVE_BIT]           = act;
      end
      wdts_pkg::OFS_IRQ_STAT: v[wdts_pkg::IRQ_W-1:0] = s.irqStat;
      wdts_pkg::OFS_IRQ_EN:   v[wdts_pkg::IRQ_W-1:0] = s.irqEn;
      wdts_pkg::OFS_COUNT:    v[wdts_pkg::CNT_W-1:0] = cnt;
      default:                v = 32'h00000000;
    endcase
    return v;
  endfunction : read_word

  assign rdValue          = read_word(rdAddr, st, watchdogModeCfg, active, wdogCount);
  assign watchdogResetReq = st.resetReq;
  assign watchdogWakeReq  = st.wakeReq;
  assign timeoutFlagN     = st.timeoutFlagN;
  assign powerdownFlagN   = st.powerdownFlagN;
  assign inSleep          = (st.pwr == wdts_pkg::PWR_SLEEP);
  assign irq              = |(st.irqStat & st.irqEn);

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  timeout_reset_a: assert property ( // R1
    wdogExpire && (st.pwr == wdts_pkg::PWR_AWAKE) |=> watchdogResetReq && !timeoutFlagN)
    else $error("awake time-out gave no reset request");

  tick_only_a: assert property ( // R2
    !lowFreqOscTick && !clearCnt |=> $stable(wdogCount))
    else $error("count moved without an oscillator tick");

  always_on_a: assert property ( // R3
    (watchdogModeCfg == wdts_pkg::MODE_ON) |-> active)
    else $error("mode 11 left the watchdog inactive");

  off_in_sleep_a: assert property ( // R4
    (watchdogModeCfg == wdts_pkg::MODE_AWAKE) && inSleep |=> (wdogCount == '0))
    else $error("mode 10 counted during sleep");

  sw_disable_a: assert property ( // R5
    (watchdogModeCfg == wdts_pkg::MODE_SW) && !swEnable |=> (wdogCount == '0) && !wdogExpire)
    else $error("mode 01 counted with software enable low");

  mode_off_a: assert property ( // R6
    (watchdogModeCfg == wdts_pkg::MODE_OFF) [*3] |-> (wdogCount == '0) && !watchdogResetReq && !watchdogWakeReq)
    else $error("mode 00 left the watchdog running");

  reset_period_a: assert property ( // R7
    !$past(resetn) |-> (periodSel == wdts_pkg::PSEL_RESET) && !swEnable)
    else $error("period select not at two seconds after reset");

  expire_point_a: assert property ( // R8
    wdogExpire |-> $past(lowFreqOscTick) && ($past(wdogCount) == wdts_pkg::term_count($past(periodSel))))
    else $error("time-out at the wrong count");

  // the clear instruction also raises both flags unless a time-out or sleep entry overrides them
  clear_instr_a: assert property ( // R9
    clearWatchdogInstr || oscFail |=> (wdogCount == '0)
      && (!$past(clearWatchdogInstr) || $past(wdogExpire) || $past(enterSleep) || (timeoutFlagN && powerdownFlagN)))
    else $error("clear did not zero the count");

  start_hold_a: assert property ( // R10
    (st.pwr == wdts_pkg::PWR_OSTHOLD) |=> (wdogCount == '0) && !watchdogResetReq)
    else $error("count moved while start-up timer held it");

  sleep_entry_a: assert property ( // R12 R14
    enterSleep && !wdogExpire |=> inSleep && !powerdownFlagN && timeoutFlagN && (wdogCount == '0))
    else $error("sleep entry did not clear count and set flags");

  sleep_wake_a: assert property ( // R13
    wdogExpire && inSleep |=> watchdogWakeReq && !watchdogResetReq && !timeoutFlagN && !powerdownFlagN && !inSleep)
    else $error("sleep time-out did not wake with flags updated");

  pulse_once_a: assert property ( // R15
    watchdogResetReq || watchdogWakeReq |=> !watchdogResetReq && !watchdogWakeReq && (wdogCount <= 23'h000001))
    else $error("time-out request wider than one cycle");

  irq_level_a: assert property (
    irqSet[wdts_pkg::IRQ_RESET_BIT] |=> st.irqStat[wdts_pkg::IRQ_RESET_BIT])
    else $error("time-out event lost from interrupt status");

  awake_timeout_c: cover property (watchdogResetReq);
  sleep_wake_c:    cover property (watchdogWakeReq ##1 (st.pwr == wdts_pkg::PWR_OSTHOLD));
  clear_race_c:    cover property (irqSet[wdts_pkg::IRQ_WAKE_BIT] && irqClr[wdts_pkg::IRQ_WAKE_BIT]);
  sw_mode_c:       cover property ((watchdogModeCfg == wdts_pkg::MODE_SW) && swEnable && wdogExpire);

endmodule : wdts_timer

//--- rtl/wdts_pkg.sv
// shared constants, types and helpers of the watchdog timer with sleep support
package wdts_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
  localparam logic [7:0] OFS_COUNT    = 8'h14;

  // watchdog_control layout: bit 0 sw_watchdog_enable, bits 5:1 watchdog_period_sel
  localparam int         CTRL_W       = 6;
  localparam int         SWEN_BIT     = 0;
  localparam int         PSEL_LSB     = 1;
  localparam int         PSEL_W       = 5;
  localparam logic [4:0] PSEL_RESET   = 5'h0B;
  localparam logic [4:0] PSEL_MAX     = 5'h12;
  localparam logic [5:0] CTRL_RESET   = {PSEL_RESET, 1'b0};

  // status layout
  localparam int ST_TMOUT_BIT  = 0;
  localparam int ST_PWRDN_BIT  = 1;
  localparam int ST_MODE_LSB   = 2;
  localparam int ST_SLEEP_BIT  = 4;
  localparam int ST_HOLD_BIT   = 5;
  localparam int ST_ACTIVE_BIT = 6;

  // interrupt sources
  localparam int IRQ_W         = 3;
  localparam int IRQ_RESET_BIT = 0;
  localparam int IRQ_WAKE_BIT  = 1;
  localparam int IRQ_OSCF_BIT  = 2;

  // time base: 31 kHz ticks, 1:32 prescale gives the nominal 1 ms base period
  localparam int         LFO_FREQ_KHZ   = 31;
  localparam int         BASE_PERIOD_MS = 1;
  localparam logic [4:0] PRESCALE_LOG2  = 5'h05;
  localparam int         CNT_W          = 23;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_SW    = 2'h1,
    MODE_AWAKE = 2'h2,
    MODE_ON    = 2'h3
  } wdts_mode_t;

  typedef enum logic [2:0] {
    PWR_AWAKE   = 3'h1,
    PWR_SLEEP   = 3'h2,
    PWR_OSTHOLD = 3'h4
  } wdts_pwr_t;

  // last count value before a time-out; reserved codes fall back to 1:32
  function automatic logic [CNT_W-1:0] term_count(input logic [4:0] sel);
    logic [4:0]     shamt;
    logic [CNT_W:0] span;
    shamt = (sel > PSEL_MAX) ? PRESCALE_LOG2 : 5'(sel + PRESCALE_LOG2);
    span  = {{CNT_W{1'b0}}, 1'b1} << shamt;
    return CNT_W'(span - {{CNT_W{1'b0}}, 1'b1});
  endfunction : term_count

  function automatic logic is_active(input logic [1:0] mode, input logic swen, input logic asleep);
    case (mode)
      MODE_ON:    return 1'b1;
      MODE_AWAKE: return !asleep;
      MODE_SW:    return swen;
      default:    return 1'b0;
    endcase
  endfunction : is_active

endpackage : wdts_pkg

//--- rtl/wdts_counter.sv
// watchdog prescaler and count, stepped by low-frequency oscillator ticks
`timescale 1ns/1ps
module wdts_counter (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  // control
  input  wire logic                      clear,
  input  wire logic                      lfoTick,
  input  wire logic [4:0]                periodSel,
  // state
  output logic      [wdts_pkg::CNT_W-1:0] count,
  output logic                           expire
);

  typedef struct packed {
    logic [wdts_pkg::CNT_W-1:0] count;
    logic                       expire;
  } wdts_cnt_t;

  wdts_cnt_t st;
  wdts_cnt_t next_st;

  always_comb begin
    next_st        = st;
    next_st.expire = 1'b0;
    if (clear) begin
      next_st.count = '0;
    end else if (lfoTick) begin
      if (st.count >= wdts_pkg::term_count(periodSel)) begin
        // restart from zero so a missed reset cannot re-fire at once
        next_st.count  = '0;
        next_st.expire = 1'b1;
      end else begin
        next_st.count = CNT_W_INC(st.count);
      end
    end
  end

  function automatic logic [wdts_pkg::CNT_W-1:0] CNT_W_INC(input logic [wdts_pkg::CNT_W-1:0] v);
    return wdts_pkg::CNT_W'(v + 1'b1);
  endfunction : CNT_W_INC

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count  = st.count;
  assign expire = st.expire;

endmodule : wdts_counter

//--- rtl/wdts_ahb_slave.sv
// zero-wait-state AHB-Lite slave front end for the watchdog registers
`timescale 1ns/1ps
module wdts_ahb_slave (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  output logic [7:0]       rdAddr,
  output logic             rdHit,
  input  wire logic [31:0] rdValue,
  output logic             wrStb,
  output logic [7:0]       wrAddr,
  output logic [31:0]      wrData
);

  typedef struct packed {
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [31:0] hrdata;
  } wdts_bus_t;

  wdts_bus_t st;
  wdts_bus_t next_st;
  logic      take;

  // only word transfers are taken; others complete OKAY with no effect
  assign take   = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign rdAddr = haddr[7:0];
  assign rdHit  = (haddr[31:8] == 24'h000000);

  always_comb begin
    next_st        = st;
    next_st.wrPend = take && hwrite && rdHit;
    if (take) begin
      next_st.wrAddr = haddr[7:0];
    end
    if (take && !hwrite) begin
      next_st.hrdata = rdHit ? rdValue : 32'h00000000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.hrdata;
  assign wrStb     = st.wrPend;
  assign wrAddr    = st.wrAddr;
  assign wrData    = hwdata;

endmodule : wdts_ahb_slave

//--- test/wdts_clock_model.sv
// low-frequency tick source and start-up timer beside the watchdog
`timescale 1ns/1ps
module wdts_clock_model #(
  parameter int TICK_DIV = 4,
  parameter int OST_LEN  = 12
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // bench control and watchdog wake
  input  wire logic tickEn,
  input  wire logic crystalClock,
  input  wire logic watchdogWakeReq,
  // to the watchdog
  output logic      lowFreqOscTick,
  output logic      oscStartupTimerRunning
);
  int divCnt;
  int ostCnt;

  // ticks stop with tickEn so the bench knows exactly how many were sent
  always @(posedge mclk) begin
    if (!resetn || !tickEn) begin
      divCnt         <= 0;
      lowFreqOscTick <= 1'b0;
    end else begin
      divCnt         <= (divCnt == TICK_DIV - 1) ? 0 : divCnt + 1;
      lowFreqOscTick <= (divCnt == TICK_DIV - 1);
    end
    if (!resetn)
      ostCnt <= 0;
    else if (watchdogWakeReq && crystalClock)
      ostCnt <= OST_LEN;
    else if (ostCnt > 0)
      ostCnt <= ostCnt - 1;
  end

  // combinational start so the timer is already running when the hold begins
  assign oscStartupTimerRunning = (ostCnt > 0) || (watchdogWakeReq && crystalClock);
endmodule : wdts_clock_model

//--- test/testbench.sv
// self-checking bench for the watchdog timer with sleep support
`timescale 1ns/1ps
module testbench;
  logic        mclk, resetn, hwrite, hreadyout, hresp, clrInstr, sleepInstr, wakeEvent, oscFail, tickEn;
  logic        crystalClock, oscStart, lfoTick, resetReq, wakeReq, toFlagN, pdFlagN, inSleep, irq;
  logic [1:0]  htrans, mode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  lfsr;
  int          n_errors, n_checks, ticks;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  wdts_timer dut_u (.mclk(mclk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .watchdogModeCfg(mode), .clearWatchdogInstr(clrInstr),
    .sleepInstr(sleepInstr), .wakeEvent(wakeEvent), .oscFail(oscFail), .crystalClock(crystalClock),
    .oscStartupTimerRunning(oscStart), .lowFreqOscTick(lfoTick), .watchdogResetReq(resetReq),
    .watchdogWakeReq(wakeReq), .timeoutFlagN(toFlagN), .powerdownFlagN(pdFlagN), .inSleep(inSleep),
    .irq(irq));

  wdts_clock_model partner_u (.mclk(mclk), .resetn(resetn), .tickEn(tickEn), .crystalClock(crystalClock),
    .watchdogWakeReq(wakeReq), .lowFreqOscTick(lfoTick), .oscStartupTimerRunning(oscStart));

  // ticks since the last restart, as the behavioural model sees them
  always @(posedge mclk) ticks <= tickEn ? ticks + int'(lfoTick) : 0;

  function automatic logic [7:0] lfsrNext(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsrNext

  // behavioural model: reserved codes fall back to the shortest interval
  function automatic int modelTicks(input int sel);
    return (sel > 18) ? 32 : 32 << sel;
  endfunction : modelTicks

  function automatic bit modelActive(input int m, input int sw, input int asleep);
    return m == 3 || (m == 2 && asleep == 0) || (m == 1 && sw == 1);
  endfunction : modelActive

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // one single word transfer; an idle edge follows so a read-back never meets the write hazard
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge mclk);
  endtask : bus

  // kind 0 clear instruction, 1 oscillator fail, 2 sleep entry
  task automatic restart(input int kind);
    tickEn     <= 1'b0;
    clrInstr   <= (kind == 0);
    oscFail    <= (kind == 1);
    sleepInstr <= (kind == 2);
    @(posedge mclk);
    {clrInstr, oscFail, sleepInstr} <= 3'h0;
    tickEn <= 1'b1;
    @(posedge mclk);
    if (kind == 2)
      check("sleep entry flags", 32'({toFlagN, pdFlagN, inSleep}), 32'h5);
  endtask : restart

  task automatic run(input int sel, input bit active, input bit asleep);
    int n;
    n = 0;
    while (n < 4 * modelTicks(sel) + 40 && resetReq !== 1'b1 && wakeReq !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    if (!active) begin
      check("quiet", 32'({resetReq, wakeReq}), 32'h0);
      bus(1'b0, wdts_pkg::OFS_COUNT, 32'h0, rd);
      check("held count", rd, 32'h0);
      return;
    end
    check("ticks", 32'(ticks), 32'(modelTicks(sel)));
    check("request", 32'({resetReq, wakeReq}), asleep ? 32'h1 : 32'h2);
    if (asleep)
      check("wake flags", 32'({toFlagN, pdFlagN, inSleep}), 32'h0);
    @(posedge mclk);
    check("pulse", 32'({resetReq, wakeReq}), 32'h0);
  endtask : run

  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  initial begin
    int sel;
    {resetn, hwrite, clrInstr, sleepInstr, wakeEvent, oscFail, crystalClock, tickEn} = '0;
    htrans = 2'h0;
    mode   = 2'h3;
    haddr  = '0;
    hwdata = '0;
    lfsr   = 8'h46;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    bus(1'b0, wdts_pkg::OFS_CONTROL, 32'h0, rd);
    check("control reset", rd, 32'h16);
    bus(1'b0, wdts_pkg::OFS_STATUS, 32'h0, rd);
    check("flags reset", 32'(rd[1:0]), 32'h3);
    bus(1'b1, 8'h40, {24'h0, lfsr}, rd);
    bus(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // every mode, enable and sleep combination
    for (int c = 0; c < 16; c++) begin
      mode <= 2'(c >> 2);
      bus(1'b1, wdts_pkg::OFS_CONTROL, 32'(c[1]), rd);
      restart(c[0] ? 2 : 0);
      run(0, modelActive(c >> 2, c[1], c[0]), c[0]);
      if (inSleep === 1'b1) begin
        wakeEvent <= 1'b1;
        @(posedge mclk);
        wakeEvent <= 1'b0;
      end
    end
    // period codes with a clear in mid-count
    mode <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsrNext(lfsr);
      sel  = i[0] ? 19 + int'(lfsr % 8'd13) : int'(lfsr % 8'd3);
      bus(1'b1, wdts_pkg::OFS_CONTROL, 32'(sel << 1), rd);
      restart(0);
      repeat (40) @(posedge mclk);
      restart(i >> 1);
      run(sel, 1'b1, 1'b0);
    end
    // crystal wake holds the count clear while the start-up timer runs
    crystalClock <= 1'b1;
    bus(1'b1, wdts_pkg::OFS_CONTROL, 32'h0, rd);
    restart(2);
    run(0, 1'b1, 1'b1);
    // let two ticks pass inside the hold, so a count that is not held would show
    repeat (6) @(posedge mclk);
    bus(1'b0, wdts_pkg::OFS_COUNT, 32'h0, rd);
    check("count in hold", rd, 32'h0);
    repeat (16) @(posedge mclk);
    bus(1'b0, wdts_pkg::OFS_STATUS, 32'h0, rd);
    check("hold left", 32'(rd[5]), 32'h0);
    crystalClock <= 1'b0;
    // interrupt raised, masked and cleared
    bus(1'b1, wdts_pkg::OFS_IRQ_CLR, 32'h7, rd);
    bus(1'b1, wdts_pkg::OFS_IRQ_EN, 32'h1, rd);
    check("irq idle", 32'(irq), 32'h0);
    restart(0);
    run(0, 1'b1, 1'b0);
    tickEn <= 1'b0;
    @(posedge mclk);
    check("irq set", 32'(irq), 32'h1);
    bus(1'b0, wdts_pkg::OFS_IRQ_STAT, 32'h0, rd);
    check("irq status", rd, 32'h1);
    bus(1'b1, wdts_pkg::OFS_IRQ_EN, 32'h0, rd);
    check("irq masked", 32'(irq), 32'h0);
    bus(1'b1, wdts_pkg::OFS_IRQ_CLR, 32'h1, rd);
    bus(1'b1, wdts_pkg::OFS_IRQ_EN, 32'h1, rd);
    check("irq cleared", 32'(irq), 32'h0);
    summarize();
  end
endmodule : testbench
